// file: common/ecx_pkg.sv
package ecx_pkg;

  // ------------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------------
  localparam logic [7:0] A_CMD      = 8'h00;
  localparam logic [7:0] A_CFG      = 8'h04;
  localparam logic [7:0] A_MASK_LO  = 8'h08;
  localparam logic [7:0] A_MASK_HI  = 8'h0c;
  localparam logic [7:0] A_FCR_LO   = 8'h10;
  localparam logic [7:0] A_FCR_HI   = 8'h14;
  localparam logic [7:0] A_PAGES    = 8'h18;
  localparam logic [7:0] A_MISC     = 8'h1c;
  localparam logic [7:0] A_STATUS   = 8'h20;
  localparam logic [7:0] A_SAVED_LO = 8'h24;
  localparam logic [7:0] A_SAVED_HI = 8'h28;
  localparam logic [7:0] A_REQ_SIZE = 8'h2c;
  localparam logic [7:0] A_PV_LO    = 8'h30;
  localparam logic [7:0] A_PV_HI    = 8'h34;
  localparam logic [7:0] A_SIMD     = 8'h38;
  localparam logic [7:0] A_HDR      = 8'h3c;
  localparam logic [7:0] A_AMSK_LO  = 8'h40;
  localparam logic [7:0] A_AMSK_HI  = 8'h44;
  localparam logic [7:0] A_MMSK     = 8'h48;
  localparam logic [7:0] A_KEY_LO   = 8'h4c;
  localparam logic [7:0] A_KEY_HI   = 8'h50;
  localparam logic [7:0] A_KEY_MISC = 8'h54;
  localparam logic [7:0] A_RPT_LO   = 8'h58;
  localparam logic [7:0] A_RPT_HI   = 8'h5c;
  localparam logic [7:0] A_RPT_MISC = 8'h60;
  localparam logic [7:0] A_TAB_IDX  = 8'h64;
  localparam logic [7:0] A_TAB_OFF  = 8'h68;
  localparam logic [7:0] A_TAB_SIZE = 8'h6c;
  localparam logic [7:0] A_COPY     = 8'h70;
  localparam logic [7:0] A_MISC_OFF = 8'h74;
  localparam logic [7:0] A_SEL_LO   = 8'h78;
  localparam logic [7:0] A_SEL_HI   = 8'h7c;

  // ------------------------------------------------------------------
  // Commands, sizes and field positions
  // ------------------------------------------------------------------
  localparam logic [2:0]  OP_CREATE  = 3'h1;
  localparam logic [2:0]  OP_ENTER   = 3'h2;
  localparam logic [2:0]  OP_RESUME  = 3'h3;
  localparam logic [2:0]  OP_EXIT    = 3'h4;
  localparam logic [2:0]  OP_AEX     = 3'h5;
  localparam logic [2:0]  OP_REPORT  = 3'h6;
  localparam logic [2:0]  OP_KEY     = 3'h7;
  localparam logic [63:0] MASK_BASE  = 64'h3;
  localparam logic [31:0] LEGACY_LEN = 32'h240;
  localparam logic [31:0] COPY_OFF   = 32'h200;
  localparam logic [5:0]  SCAN_FIRST = 6'h02;
  localparam logic [5:0]  SCAN_LAST  = 6'h3f;
  localparam int          PAGE_SHIFT = 12;

  typedef struct packed {
    logic is64;
    logic system_management_mode;
    logic osx_en;
    logic simd_en;
    logic xsave;
  } ecx_cfg_t;

  function automatic logic [31:0] be_merge(input logic [31:0] old,
                                           input logic [31:0] nw,
                                           input logic [3:0]  sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
    begin
      if (sel[b])
        r[8*b +: 8] = nw[8*b +: 8];
    end
    return r;
  endfunction : be_merge

endpackage : ecx_pkg

// file: rtl/ecx_core.sv
// What this block does
// - Create faults unless mask low bits equal three.
// - No xsave: create faults on high bits, zero pages.
// - Xsave: create faults on illegal mask or bit63.
// - No xsave: area 576 bytes, mask copy 512.
// - Xsave: size by scanning component offsets, sizes.
// - Area at frame start; misc sits before gprs.
// - Xsave: frame pages checked against the previous req_size, misc, gprs.
// - Enter faults on simd, os_extended_save_enable, mask subset errors.
// - Enter saves control register, loads the mask.
// - Async exit saves state, clears unmasked present bits.
// - Async exit restores control register, synthesizes state.
// - Resume repeats the entry fault checks.
// - Resume faults on bad saved area content.
// - Resume saves register, loads mask, restores state.
// - Resume marks all state as modified.
// - Exit skips enable and mask checks, restores the control register.
// - Report carries mask and misc selection.
// - Key mixes only selected mask and misc bits.
// - System management mode blocks enclave ops.
// - Mask bits map onto control register bits.
`timescale 1ns/1ps
`default_nettype none

module ecx_core #(
  parameter logic [63:0] FCR_SUPPORTED = 64'h0000_0000_0000_00ff,
  parameter logic [31:0] SIMD_RSVD     = 32'hffff_0000,
  parameter logic [31:0] GPR_BYTES     = 32'h0000_00c0,
  parameter logic [31:0] MISC_BYTES    = 32'h0000_0010
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Status
  output logic             in_enclave_o,
  output logic             done_o,
  output logic             gp_fault_o,
  output logic             ud_fault_o
);

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_CHK  = 4'b0010,
    S_SCAN = 4'b0100,
    S_FIN  = 4'b1000
  } ecx_state_t;

  ecx_state_t       st;
  ecx_pkg::ecx_cfg_t cfg;
  logic [2:0]  op;
  logic [63:0] mask, fcr, saved, pv, amsk, key, rpt, sel, copy;
  logic [31:0] pages, misc, simd, hdr, mmsk, key_misc, rpt_misc;
  logic [31:0] req_size, off, last;
  logic [5:0]  tab_idx, idx;
  logic        st_gp, st_ud;
  logic [31:0] comp_off  [0:63];
  logic [31:0] comp_size [0:63];

  // ------------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------------
  wire logic req = wb_cyc_i & wb_stb_i;
  wire logic wr  = req & wb_ack_o & wb_we_i;
  wire logic [31:0] wd  = wb_dat_i;
  wire logic [3:0]  be  = wb_sel_i;
  wire logic w_cmd   = wr & (wb_adr_i == ecx_pkg::A_CMD);
  wire logic w_cfg   = wr & (wb_adr_i == ecx_pkg::A_CFG);
  wire logic w_mlo   = wr & (wb_adr_i == ecx_pkg::A_MASK_LO);
  wire logic w_mhi   = wr & (wb_adr_i == ecx_pkg::A_MASK_HI);
  wire logic w_flo   = wr & (wb_adr_i == ecx_pkg::A_FCR_LO);
  wire logic w_fhi   = wr & (wb_adr_i == ecx_pkg::A_FCR_HI);
  wire logic w_pages = wr & (wb_adr_i == ecx_pkg::A_PAGES);
  wire logic w_misc  = wr & (wb_adr_i == ecx_pkg::A_MISC);
  wire logic w_plo   = wr & (wb_adr_i == ecx_pkg::A_PV_LO);
  wire logic w_phi   = wr & (wb_adr_i == ecx_pkg::A_PV_HI);
  wire logic w_simd  = wr & (wb_adr_i == ecx_pkg::A_SIMD);
  wire logic w_hdr   = wr & (wb_adr_i == ecx_pkg::A_HDR);
  wire logic w_alo   = wr & (wb_adr_i == ecx_pkg::A_AMSK_LO);
  wire logic w_ahi   = wr & (wb_adr_i == ecx_pkg::A_AMSK_HI);
  wire logic w_mmsk  = wr & (wb_adr_i == ecx_pkg::A_MMSK);
  wire logic w_tidx  = wr & (wb_adr_i == ecx_pkg::A_TAB_IDX);
  wire logic w_toff  = wr & (wb_adr_i == ecx_pkg::A_TAB_OFF);
  wire logic w_tsz   = wr & (wb_adr_i == ecx_pkg::A_TAB_SIZE);

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  wire logic is_crt = (op == ecx_pkg::OP_CREATE);
  wire logic is_ent = (op == ecx_pkg::OP_ENTER);
  wire logic is_res = (op == ecx_pkg::OP_RESUME);
  wire logic is_ext = (op == ecx_pkg::OP_EXIT);
  wire logic is_aex = (op == ecx_pkg::OP_AEX);
  wire logic is_rpt = (op == ecx_pkg::OP_REPORT);
  wire logic is_key = (op == ecx_pkg::OP_KEY);
  wire logic is_out = is_ext | is_aex | is_rpt | is_key;
  // Loading the mask into the control register must be legal.
  wire logic fcr_bad = |(mask & ~FCR_SUPPORTED) | ~mask[0];
  wire logic crt_bad = (mask[1:0] != ecx_pkg::MASK_BASE[1:0])
    | (~cfg.xsave & ((|mask[63:2]) | (pages == '0)))
    | (cfg.xsave & (fcr_bad | mask[63]));
  wire logic ent_bad = ~cfg.simd_en | (cfg.xsave
    & ((~cfg.osx_en & (mask != ecx_pkg::MASK_BASE))
    | ((mask & fcr) != mask)));
  // Saved-area faults apply even with the os enable clear.
  wire logic rst_bad = (|(pv & ~mask)) | (|hdr)
    | (|(simd & SIMD_RSVD));
  wire logic gp_now = (is_crt & crt_bad)
    | ((is_ent | is_res) & (ent_bad | in_enclave_o))
    | (is_res & rst_bad) | (is_out & ~in_enclave_o);
  wire logic chk   = (st == S_CHK);
  wire logic ok    = chk & ~cfg.system_management_mode & ~gp_now;
  wire logic start = w_cmd & (st == S_IDLE);

  // ------------------------------------------------------------------
  // Frame sizing
  // ------------------------------------------------------------------
  wire logic [31:0] end_cur  = off + last;
  wire logic [31:0] misc_sz  = (misc != '0) ? MISC_BYTES : '0;
  wire logic [43:0] need     = {12'h000, req_size} + {12'h000, misc_sz}
                               + {12'h000, GPR_BYTES};
  wire logic [43:0] frame    = {12'h000, pages} << ecx_pkg::PAGE_SHIFT;
  wire logic        size_bad = frame < need;
  // Xsave area starts at byte 0; misc ends where gprs begin.
  wire logic [31:0] misc_off = frame[31:0] - GPR_BYTES - misc_sz;

  // ------------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st <= S_IDLE;
      op <= '0;
      done_o <= 1'b0;
      gp_fault_o <= 1'b0;
      ud_fault_o <= 1'b0;
      idx <= ecx_pkg::SCAN_FIRST;
      off <= '0;
      last <= '0;
    end
    else
    begin
      done_o <= 1'b0;
      gp_fault_o <= 1'b0;
      ud_fault_o <= 1'b0;
      unique case (st)
        S_IDLE:
        begin
          if (start)
          begin
            op <= wd[2:0];
            st <= S_CHK;
          end
        end
        S_CHK:
        begin
          idx <= ecx_pkg::SCAN_FIRST;
          off <= ecx_pkg::LEGACY_LEN;
          last <= '0;
          if (ok & is_crt & cfg.xsave)
            st <= S_SCAN;
          else
          begin
            st <= S_IDLE;
            done_o <= 1'b1;
            ud_fault_o <= cfg.system_management_mode;
            gp_fault_o <= ~cfg.system_management_mode & gp_now;
          end
        end
        S_SCAN:
        begin
          // One component per cycle keeps the adder path short.
          if (mask[idx] && comp_off[idx] >= end_cur)
          begin
            off <= comp_off[idx];
            last <= comp_size[idx];
          end
          idx <= idx + 6'h01;
          if (idx == ecx_pkg::SCAN_LAST)
            st <= S_FIN;
        end
        S_FIN:
        begin
          st <= S_IDLE;
          done_o <= 1'b1;
          gp_fault_o <= size_bad;
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Enclave state and control register swap
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      in_enclave_o <= 1'b0;
      fcr <= ecx_pkg::MASK_BASE;
      saved <= ecx_pkg::MASK_BASE;
      req_size <= ecx_pkg::LEGACY_LEN;
      st_gp <= 1'b0;
      st_ud <= 1'b0;
    end
    else
    begin
      if (done_o)
      begin
        st_gp <= gp_fault_o;
        st_ud <= ud_fault_o;
      end
      if (ok & (is_ent | is_res))
      begin
        in_enclave_o <= 1'b1;
        saved <= fcr;
        fcr <= mask;
      end
      else if (ok & (is_ext | is_aex))
      begin
        in_enclave_o <= 1'b0;
        fcr <= saved;
      end
      else if (w_flo)
        fcr[31:0] <= ecx_pkg::be_merge(fcr[31:0], wd, be);
      else if (w_fhi)
        fcr[63:32] <= ecx_pkg::be_merge(fcr[63:32], wd, be);
      if (ok & is_crt & ~cfg.xsave)
        req_size <= ecx_pkg::LEGACY_LEN;
      else if (st == S_FIN)
        req_size <= end_cur;
    end
  end

  // ------------------------------------------------------------------
  // Save area, report and key outputs
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pv <= '0;
      sel <= '0;
      copy <= '0;
      rpt <= '0;
      rpt_misc <= '0;
      key <= '0;
      key_misc <= '0;
    end
    else
    begin
      if (ok & is_aex)
      begin
        pv <= pv & mask;
        // Selector names the components forced to their init state.
        sel <= mask;
        if (~cfg.xsave)
          copy <= mask;
      end
      else if (ok & is_res)
        sel <= '1;
      else if (w_plo)
        pv[31:0] <= ecx_pkg::be_merge(pv[31:0], wd, be);
      else if (w_phi)
        pv[63:32] <= ecx_pkg::be_merge(pv[63:32], wd, be);
      if (ok & is_rpt)
      begin
        rpt <= mask;
        rpt_misc <= misc;
      end
      if (ok & is_key)
      begin
        key <= mask & amsk;
        key_misc <= misc & mmsk;
      end
    end
  end

  // ------------------------------------------------------------------
  // Software registers
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cfg <= '0;
      mask <= ecx_pkg::MASK_BASE;
      pages <= '0;
      misc <= '0;
      simd <= '0;
      hdr <= '0;
      amsk <= '0;
      mmsk <= '0;
      tab_idx <= '0;
    end
    else
    begin
      if (w_cfg)
        cfg <= wd[$bits(cfg)-1:0];
      if (w_mlo)
        mask[31:0] <= ecx_pkg::be_merge(mask[31:0], wd, be);
      if (w_mhi)
        mask[63:32] <= ecx_pkg::be_merge(mask[63:32], wd, be);
      if (w_pages)
        pages <= ecx_pkg::be_merge(pages, wd, be);
      if (w_misc)
        misc <= ecx_pkg::be_merge(misc, wd, be);
      if (w_simd)
        simd <= ecx_pkg::be_merge(simd, wd, be);
      if (w_hdr)
        hdr <= ecx_pkg::be_merge(hdr, wd, be);
      if (w_alo)
        amsk[31:0] <= ecx_pkg::be_merge(amsk[31:0], wd, be);
      if (w_ahi)
        amsk[63:32] <= ecx_pkg::be_merge(amsk[63:32], wd, be);
      if (w_mmsk)
        mmsk <= ecx_pkg::be_merge(mmsk, wd, be);
      if (w_tidx)
        tab_idx <= wd[5:0];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (w_toff)
      comp_off[tab_idx] <= wd;
    if (w_tsz)
      comp_size[tab_idx] <= wd;
  end

  // ------------------------------------------------------------------
  // Read mux and acknowledge
  // ------------------------------------------------------------------
  wire logic [31:0] rd [0:31];
  assign rd[0]  = {29'h0, op};
  assign rd[1]  = {27'h0, cfg};
  assign rd[2]  = mask[31:0];
  assign rd[3]  = mask[63:32];
  assign rd[4]  = fcr[31:0];
  assign rd[5]  = fcr[63:32];
  assign rd[6]  = pages;
  assign rd[7]  = misc;
  assign rd[8]  = {27'h0, cfg.is64, in_enclave_o, st_ud, st_gp,
                   st != S_IDLE};
  assign rd[9]  = saved[31:0];
  assign rd[10] = saved[63:32];
  assign rd[11] = req_size;
  assign rd[12] = pv[31:0];
  assign rd[13] = pv[63:32];
  assign rd[14] = simd;
  assign rd[15] = hdr;
  assign rd[16] = amsk[31:0];
  assign rd[17] = amsk[63:32];
  assign rd[18] = mmsk;
  assign rd[19] = key[31:0];
  assign rd[20] = key[63:32];
  assign rd[21] = key_misc;
  assign rd[22] = rpt[31:0];
  assign rd[23] = rpt[63:32];
  assign rd[24] = rpt_misc;
  assign rd[25] = {26'h0, tab_idx};
  assign rd[26] = comp_off[tab_idx];
  assign rd[27] = comp_size[tab_idx];
  assign rd[28] = copy[31:0];
  assign rd[29] = misc_off;
  assign rd[30] = sel[31:0];
  assign rd[31] = sel[63:32];
  // Unmapped words above the map read as zero and are still acked.
  wire logic [31:0] rdata = wb_adr_i[7] ? '0 : rd[wb_adr_i[6:2]];

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end
    else
    begin
      wb_ack_o <= req & ~wb_ack_o;
      wb_dat_o <= rdata;
    end
  end

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_create_lowbits: assert property (
    chk & is_crt & ~cfg.system_management_mode & (mask[1:0] != ecx_pkg::MASK_BASE[1:0])
    |=> gp_fault_o && done_o)
    else $error("create accepted bad low mask bits");
  chk_create_nopages: assert property (
    chk & is_crt & ~cfg.system_management_mode & ~cfg.xsave & (pages == '0)
    |=> gp_fault_o)
    else $error("create accepted zero pages");
  chk_create_top: assert property (
    chk & is_crt & ~cfg.system_management_mode & cfg.xsave & mask[63] |=> gp_fault_o)
    else $error("create accepted mask bit 63");
  chk_scan_length: assert property (
    $rose(st == S_SCAN) |-> ##62 (st == S_FIN) ##1 done_o)
    else $error("size scan length wrong");
  chk_enter_swap: assert property (
    ok & is_ent |=> fcr == $past(mask) && saved == $past(fcr))
    else $error("entry did not swap control register");
  chk_exit_restore: assert property (
    ok & is_ext |=> fcr == $past(saved) && !in_enclave_o)
    else $error("exit did not restore control register");
  chk_aex_present: assert property (
    ok & is_aex |=> (pv & ~$past(mask)) == '0 && sel == $past(mask))
    else $error("async exit left unmasked present bits");
  chk_enter_subset: assert property (
    chk & is_ent & ~cfg.system_management_mode & cfg.xsave & ((mask & fcr) != mask)
    |=> gp_fault_o)
    else $error("entry accepted mask outside register");
  chk_resume_area: assert property (
    chk & is_res & ~cfg.system_management_mode & (|hdr) |=> gp_fault_o ##1 !gp_fault_o)
    else $error("resume accepted dirty header");
  chk_smm_block: assert property (
    chk & cfg.system_management_mode |=> ud_fault_o && !gp_fault_o && done_o)
    else $error("enclave op ran in management mode");
  chk_key_mix: assert property (
    ok & is_key |=> key == ($past(mask) & $past(amsk)))
    else $error("key mix used unselected bits");

  cov_create_scan: cover property ((st == S_FIN) ##1 !gp_fault_o);
  cov_enter_ok: cover property (ok & is_ent);
  cov_aex_resume: cover property (ok & is_aex ##[1:400] ok & is_res);

endmodule : ecx_core

`default_nettype wire

// file: bench/ecx_core_test.sv
`timescale 1ns/1ps
`default_nettype none

module ecx_core_test;

  // ------------------------------------------------------------------
  // Stimulus and observed signals
  // ------------------------------------------------------------------
  logic        clk_i;
  logic        rst_i;
  logic        wb_cyc_i;
  logic        wb_stb_i;
  logic        wb_we_i;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        in_enclave_o;
  logic        done_o;
  logic        gp_fault_o;
  logic        ud_fault_o;
  int          n_errors;
  int          comparisons;

  ecx_core dut (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .wb_cyc_i     (wb_cyc_i),
    .wb_stb_i     (wb_stb_i),
    .wb_we_i      (wb_we_i),
    .wb_adr_i     (wb_adr_i),
    .wb_sel_i     (wb_sel_i),
    .wb_dat_i     (wb_dat_i),
    .wb_dat_o     (wb_dat_o),
    .wb_ack_o     (wb_ack_o),
    .in_enclave_o (in_enclave_o),
    .done_o       (done_o),
    .gp_fault_o   (gp_fault_o),
    .ud_fault_o   (ud_fault_o)
  );

  always #10 clk_i = ~clk_i;

  // ------------------------------------------------------------------
  // Bus, command and compare tasks
  // ------------------------------------------------------------------
  task automatic close_out();
    $display("checks %0d, mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : close_out

  task automatic tmo();
    n_errors++;
    $display("CHECK FAILED at %0t: wait ran out", $time);
    close_out();
  endtask : tmo

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED at %0t: word %h, want %h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_b(input logic got, input logic exp);
    comparisons++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED at %0t: flag %b, want %b", $time, got, exp);
    end
  endtask : chk_b

  // Ack and read data are taken at the rising edge that samples ack
  // high; the request is released only after that edge.
  task automatic wb(input logic we, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50)
      tmo();
    else
    begin
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i  <= 1'b0;
    end
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask : rd

  task automatic tab(input logic [5:0] i, input logic [31:0] o,
                     input logic [31:0] s);
    wr(ecx_pkg::A_TAB_IDX, {26'h0, i});
    wr(ecx_pkg::A_TAB_OFF, o);
    wr(ecx_pkg::A_TAB_SIZE, s);
  endtask : tab

  // Sets configuration and mask, issues the command, checks both faults.
  task automatic run(input logic [2:0] op, input ecx_pkg::ecx_cfg_t c,
                     input logic [31:0] mlo, input logic [31:0] mhi,
                     input logic eg, input logic eu);
    int n;
    wr(ecx_pkg::A_CFG, {27'h0, c});
    wr(ecx_pkg::A_MASK_LO, mlo);
    wr(ecx_pkg::A_MASK_HI, mhi);
    wr(ecx_pkg::A_CMD, {29'h0, op});
    n = 0;
    do
    begin
      @(negedge clk_i);
      n++;
    end
    while (done_o !== 1'b1 && n < 200);
    if (n >= 200)
      tmo();
    else
    begin
      chk_b(gp_fault_o, eg);
      chk_b(ud_fault_o, eu);
    end
  endtask : run

  // ------------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------------
  initial
  begin
    clk_i = 1'b0; rst_i = 1'b1; wb_cyc_i = 1'b0; wb_stb_i = 1'b0;
    wb_we_i = 1'b0; wb_adr_i = 8'h00; wb_sel_i = 4'h0; wb_dat_i = 32'h0;
    n_errors = 0;
    comparisons = 0;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(ecx_pkg::A_SAVED_LO, 32'h3);
    rd(ecx_pkg::A_REQ_SIZE, ecx_pkg::LEGACY_LEN);
    rd(8'h84, 32'h0);
    $display("test reset done");
    wr(ecx_pkg::A_PAGES, 32'h1);
    run(ecx_pkg::OP_CREATE, 5'h02, 32'h1, 32'h0, 1'b1, 1'b0);
    run(ecx_pkg::OP_CREATE, 5'h02, 32'h3, 32'h1, 1'b1, 1'b0);
    run(ecx_pkg::OP_CREATE, 5'h02, 32'h7, 32'h0, 1'b1, 1'b0);
    wr(ecx_pkg::A_PAGES, 32'h0);
    run(ecx_pkg::OP_CREATE, 5'h02, 32'h3, 32'h0, 1'b1, 1'b0);
    wr(ecx_pkg::A_PAGES, 32'h1);
    run(ecx_pkg::OP_CREATE, 5'h02, 32'h3, 32'h0, 1'b0, 1'b0);
    rd(ecx_pkg::A_REQ_SIZE, ecx_pkg::LEGACY_LEN);
    run(ecx_pkg::OP_ENTER, 5'h00, 32'h3, 32'h0, 1'b1, 1'b0);
    run(ecx_pkg::OP_ENTER, 5'h02, 32'h3, 32'h0, 1'b0, 1'b0);
    chk_b(in_enclave_o, 1'b1);
    run(ecx_pkg::OP_AEX, 5'h02, 32'h3, 32'h0, 1'b0, 1'b0);
    rd(ecx_pkg::A_COPY, 32'h3);
    chk_b(in_enclave_o, 1'b0);
    $display("test legacy frame done");
    // Entry 4 starts below the running end, so the scan must skip it.
    tab(6'h02, 32'h240, 32'h100);
    tab(6'h03, 32'h340, 32'h40);
    tab(6'h04, 32'h300, 32'h80);
    run(ecx_pkg::OP_CREATE, 5'h07, 32'h1f, 32'h0, 1'b0, 1'b0);
    rd(ecx_pkg::A_REQ_SIZE, 32'h380);
    run(ecx_pkg::OP_CREATE, 5'h07, 32'h1f, 32'h8000_0000, 1'b1, 1'b0);
    run(ecx_pkg::OP_CREATE, 5'h07, 32'h11f, 32'h0, 1'b1, 1'b0);
    wr(ecx_pkg::A_PAGES, 32'h0);
    run(ecx_pkg::OP_CREATE, 5'h07, 32'h1f, 32'h0, 1'b1, 1'b0);
    wr(ecx_pkg::A_PAGES, 32'h1);
    run(ecx_pkg::OP_CREATE, 5'h07, 32'h1f, 32'h0, 1'b0, 1'b0);
    $display("test sizing done");
    wr(ecx_pkg::A_FCR_LO, 32'h7);
    run(ecx_pkg::OP_ENTER, 5'h03, 32'h1f, 32'h0, 1'b1, 1'b0);
    run(ecx_pkg::OP_ENTER, 5'h07, 32'h1f, 32'h0, 1'b1, 1'b0);
    wr(ecx_pkg::A_FCR_LO, 32'hff);
    run(ecx_pkg::OP_ENTER, 5'h17, 32'h1f, 32'h0, 1'b0, 1'b0);
    rd(ecx_pkg::A_FCR_LO, 32'h1f);
    rd(ecx_pkg::A_SAVED_LO, 32'hff);
    wr(ecx_pkg::A_PV_LO, 32'hffff_ffff);
    wr(ecx_pkg::A_PV_HI, 32'hffff_ffff);
    run(ecx_pkg::OP_AEX, 5'h17, 32'h1f, 32'h0, 1'b0, 1'b0);
    rd(ecx_pkg::A_PV_LO, 32'h1f);
    rd(ecx_pkg::A_PV_HI, 32'h0);
    rd(ecx_pkg::A_FCR_LO, 32'hff);
    rd(ecx_pkg::A_SEL_LO, 32'h1f);
    $display("test entry and async exit done");
    wr(ecx_pkg::A_PV_LO, 32'h3f);
    run(ecx_pkg::OP_RESUME, 5'h17, 32'h1f, 32'h0, 1'b1, 1'b0);
    wr(ecx_pkg::A_PV_LO, 32'h3);
    wr(ecx_pkg::A_HDR, 32'h1);
    run(ecx_pkg::OP_RESUME, 5'h03, 32'h3, 32'h0, 1'b1, 1'b0);
    wr(ecx_pkg::A_HDR, 32'h0);
    wr(ecx_pkg::A_SIMD, 32'h0001_0000);
    run(ecx_pkg::OP_RESUME, 5'h17, 32'h1f, 32'h0, 1'b1, 1'b0);
    wr(ecx_pkg::A_SIMD, 32'h1f80);
    run(ecx_pkg::OP_RESUME, 5'h15, 32'h1f, 32'h0, 1'b1, 1'b0);
    run(ecx_pkg::OP_RESUME, 5'h17, 32'h1f, 32'h0, 1'b0, 1'b0);
    rd(ecx_pkg::A_FCR_LO, 32'h1f);
    rd(ecx_pkg::A_SAVED_LO, 32'hff);
    rd(ecx_pkg::A_SEL_HI, 32'hffff_ffff);
    $display("test resume done");
    wr(ecx_pkg::A_MISC, 32'h5);
    run(ecx_pkg::OP_REPORT, 5'h17, 32'h1f, 32'h0, 1'b0, 1'b0);
    rd(ecx_pkg::A_RPT_LO, 32'h1f);
    rd(ecx_pkg::A_RPT_MISC, 32'h5);
    rd(ecx_pkg::A_MISC_OFF, 32'hf30);
    wr(ecx_pkg::A_AMSK_LO, 32'h6);
    wr(ecx_pkg::A_MMSK, 32'h4);
    run(ecx_pkg::OP_KEY, 5'h17, 32'h1f, 32'h0, 1'b0, 1'b0);
    rd(ecx_pkg::A_KEY_LO, 32'h6);
    rd(ecx_pkg::A_KEY_MISC, 32'h4);
    // Exit with every enable cleared still has to succeed.
    run(ecx_pkg::OP_EXIT, 5'h00, 32'h1f, 32'h0, 1'b0, 1'b0);
    rd(ecx_pkg::A_FCR_LO, 32'hff);
    chk_b(in_enclave_o, 1'b0);
    $display("test report key exit done");
    for (int op = 1; op < 8; op++)
    begin
      run(op[2:0], 5'h0f, 32'h3, 32'h0, 1'b0, 1'b1);
    end
    rd(ecx_pkg::A_STATUS, 32'h4);
    $display("test management mode done");
    close_out();
  end

endmodule : ecx_core_test

`default_nettype wire
